//--- core/bridge_ctl_pkg.sv
package bridge_ctl_pkg;

  // ---------------------------------------------------------------
  // configuration space map (dword byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  BRIDGE_CTL_ADDR    = 8'h3c;
  localparam logic [7:0]  CHIP_CTL_ADDR      = 8'h40;

  // ---------------------------------------------------------------
  // bridge control, upper half fields
  // ---------------------------------------------------------------
  localparam int          FAST_B2B_BIT       = 23;
  localparam int          PRI_TMO_SEL_BIT    = 24;
  localparam int          SEC_TMO_SEL_BIT    = 25;
  localparam int          TMO_STATUS_BIT     = 26;
  localparam int          TMO_SERR_EN_BIT    = 27;
  localparam int          BRIDGE_LANE        = 3;

  // ---------------------------------------------------------------
  // chip control byte fields
  // ---------------------------------------------------------------
  localparam int          WR_DISC_BIT        = 1;
  localparam int          PF_DISABLE_BIT     = 4;
  localparam int          LIVE_INS_BIT       = 5;
  localparam int          CHIP_LANE          = 0;
  localparam logic [7:0]  CHIP_CTL_RESET     = 8'h00;
  localparam logic [7:0]  CHIP_CTL_WMASK     = 8'h32;

  // ---------------------------------------------------------------
  // master time-out limits in bus clock cycles
  // ---------------------------------------------------------------
  localparam int          TMO_LONG_CYCLES    = 32768;
  localparam int          TMO_SHORT_CYCLES   = 1024;
  localparam int          TMO_CNT_W          = 15;
  localparam int          NUM_SIDES          = 2;

  typedef enum logic [1:0] {
    RD_MEM,
    RD_MEM_LINE,
    RD_MEM_MULTIPLE
  } read_cmd_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  byte_enable_n;
  } cfg_req_t;

  typedef struct packed {
    logic cpl_at_head;
    logic repeat_seen;
    logic cpl_gone;
  } dly_evt_t;

endpackage

//--- core/bridge_timeout_and_chip_control.sv
module bridge_timeout_and_chip_control
  import bridge_ctl_pkg::*;
#(
  parameter int LONG_LIMIT  = TMO_LONG_CYCLES,
  parameter int SHORT_LIMIT = TMO_SHORT_CYCLES
) (
  input  wire logic      clk,
  input  wire logic      rst_b,
  // configuration cycles
  input  wire cfg_req_t  cfg_req,
  output logic [31:0]    cfg_rdata,
  // command register enables held elsewhere
  input  wire logic      cmd_io_en,
  input  wire logic      cmd_mem_en,
  input  wire logic      cmd_master_en,
  input  wire logic      cmd_serr_en,
  // delayed transaction events, index 0 primary, 1 secondary
  input  wire dly_evt_t  dly_evt [NUM_SIDES],
  output logic           dly_discard [NUM_SIDES],
  output logic           primary_system_error_out_n,
  // memory write target disconnect
  input  wire logic      wr_queue_full,
  input  wire logic      wr_at_4k_boundary,
  input  wire logic      wr_at_line_boundary,
  output logic           wr_disconnect,
  // upstream memory read policy
  input  wire read_cmd_t us_read_cmd,
  output logic           us_prefetch,
  output logic           us_forward_be,
  output logic           us_single_dword,
  output logic           us_disconnect_first,
  // live insertion
  input  wire logic      hot_insert_pin,
  input  wire logic      hot_pin_input_only,
  output logic           eff_io_en,
  output logic           eff_mem_en,
  output logic           eff_master_en,
  output logic           accept_io_mem,
  output logic           fast_b2b_gen
);

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  function automatic logic lane_hit(input cfg_req_t r, input logic [7:0] a, input int lane);
    lane_hit = r.wr && (r.addr == a) && !r.byte_enable_n[lane];
  endfunction

  logic       bridge_wr;
  logic       chip_wr;
  logic [7:0] bridge_byte;
  logic [7:0] chip_byte;

  always_comb begin
    bridge_wr   = lane_hit(cfg_req, BRIDGE_CTL_ADDR, BRIDGE_LANE);
    chip_wr     = lane_hit(cfg_req, CHIP_CTL_ADDR, CHIP_LANE);
    bridge_byte = cfg_req.wdata[31:24];
    chip_byte   = cfg_req.wdata[7:0];
  end

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  logic [7:0] chip_q;
  logic [7:0] chip_d;
  logic       pri_sel_q;
  logic       pri_sel_d;
  logic       sec_sel_q;
  logic       sec_sel_d;
  logic       serr_en_q;
  logic       serr_en_d;
  logic       status_q;
  logic       status_d;
  logic       any_discard;

  always_comb begin
    chip_d    = chip_q;
    pri_sel_d = pri_sel_q;
    sec_sel_d = sec_sel_q;
    serr_en_d = serr_en_q;
    status_d  = status_q;
    if (chip_wr) begin
      chip_d = chip_byte & CHIP_CTL_WMASK;
    end
    if (bridge_wr) begin
      pri_sel_d = bridge_byte[PRI_TMO_SEL_BIT - 24];
      sec_sel_d = bridge_byte[SEC_TMO_SEL_BIT - 24];
      serr_en_d = bridge_byte[TMO_SERR_EN_BIT - 24];
      if (bridge_byte[TMO_STATUS_BIT - 24]) begin
        status_d = 1'b0;
      end
    end
    // a discard in the clearing cycle keeps the bit set
    if (any_discard) begin
      status_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chip_q    <= CHIP_CTL_RESET;
      pri_sel_q <= 1'b0;
      sec_sel_q <= 1'b0;
      serr_en_q <= 1'b0;
      status_q  <= 1'b0;
    end else begin
      chip_q    <= chip_d;
      pri_sel_q <= pri_sel_d;
      sec_sel_q <= sec_sel_d;
      serr_en_q <= serr_en_d;
      status_q  <= status_d;
    end
  end

  // ---------------------------------------------------------------
  // master time-out counters
  // ---------------------------------------------------------------
  localparam logic [TMO_CNT_W-1:0] LONG_LAST  = TMO_CNT_W'(LONG_LIMIT - 1);
  localparam logic [TMO_CNT_W-1:0] SHORT_LAST = TMO_CNT_W'(SHORT_LIMIT - 1);

  logic side_sel [NUM_SIDES];
  logic disc_vec [NUM_SIDES];

  always_comb begin
    side_sel[0] = pri_sel_q;
    side_sel[1] = sec_sel_q;
  end

  for (genvar s = 0; s < NUM_SIDES; s++) begin : g_side
    logic                 run_q;
    logic                 run_d;
    logic [TMO_CNT_W-1:0] cnt_q;
    logic [TMO_CNT_W-1:0] cnt_d;
    logic                 disc_q;
    logic                 disc_d;
    logic [TMO_CNT_W-1:0] last;

    always_comb begin
      last   = side_sel[s] ? SHORT_LAST : LONG_LAST;
      run_d  = run_q;
      cnt_d  = cnt_q;
      disc_d = 1'b0;
      if (dly_evt[s].repeat_seen || dly_evt[s].cpl_gone) begin
        run_d = 1'b0;
        cnt_d = '0;
      end else if (run_q) begin
        if (cnt_q >= last) begin
          run_d  = 1'b0;
          cnt_d  = '0;
          disc_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      // a head pulse while running is ignored: one completion per side
      end else if (dly_evt[s].cpl_at_head) begin
        run_d = 1'b1;
        cnt_d = '0;
      end
    end

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        run_q  <= 1'b0;
        cnt_q  <= '0;
        disc_q <= 1'b0;
      end else begin
        run_q  <= run_d;
        cnt_q  <= cnt_d;
        disc_q <= disc_d;
      end
    end

    assign disc_vec[s]    = disc_q;
    assign dly_discard[s] = disc_q;
  end

  assign any_discard = disc_vec[0] || disc_vec[1];

  // ---------------------------------------------------------------
  // system error
  // ---------------------------------------------------------------
  logic serr_n_q;
  logic serr_n_d;

  // built from the registered discard, so the pulse trails it by one cycle
  always_comb begin
    serr_n_d = !(any_discard && serr_en_q && cmd_serr_en);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serr_n_q <= 1'b1;
    end else begin
      serr_n_q <= serr_n_d;
    end
  end

  assign primary_system_error_out_n = serr_n_q;

  // ---------------------------------------------------------------
  // configuration read data
  // ---------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // held until the next read
  always_comb begin
    rdata_d = rdata_q;
    if (cfg_req.rd) begin
      rdata_d = '0;
      if (cfg_req.addr == BRIDGE_CTL_ADDR) begin
        rdata_d[FAST_B2B_BIT]    = 1'b0;
        rdata_d[PRI_TMO_SEL_BIT] = pri_sel_q;
        rdata_d[SEC_TMO_SEL_BIT] = sec_sel_q;
        rdata_d[TMO_STATUS_BIT]  = status_q;
        rdata_d[TMO_SERR_EN_BIT] = serr_en_q;
      end else if (cfg_req.addr == CHIP_CTL_ADDR) begin
        rdata_d[7:0] = chip_q & CHIP_CTL_WMASK;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign cfg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // memory write target disconnect
  // ---------------------------------------------------------------
  logic line_disc;

  always_comb begin
    line_disc     = chip_q[WR_DISC_BIT] && wr_at_line_boundary;
    wr_disconnect = wr_queue_full || wr_at_4k_boundary || line_disc;
  end

  // ---------------------------------------------------------------
  // upstream memory read policy
  // ---------------------------------------------------------------
  logic short_rd;

  always_comb begin
    // line and multiple reads stay prefetchable regardless
    short_rd            = chip_q[PF_DISABLE_BIT] && (us_read_cmd == RD_MEM);
    us_prefetch         = !short_rd;
    us_forward_be       = short_rd;
    us_single_dword     = short_rd;
    us_disconnect_first = short_rd;
    fast_b2b_gen        = 1'b0;
  end

  // ---------------------------------------------------------------
  // live insertion masking
  // ---------------------------------------------------------------
  logic masked;

  // pin sampled as a level; mode 0 leaves the enables untouched
  assign masked = chip_q[LIVE_INS_BIT] && hot_pin_input_only && hot_insert_pin;

  logic [2:0] en_q;
  logic [2:0] en_d;

  always_comb begin
    en_d = masked ? 3'h0 : {cmd_master_en, cmd_mem_en, cmd_io_en};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= 3'h0;
    end else begin
      en_q <= en_d;
    end
  end

  assign eff_io_en     = en_q[0];
  assign eff_mem_en    = en_q[1];
  assign eff_master_en = en_q[2];
  assign accept_io_mem = !masked && (en_q[0] || en_q[1]);

endmodule

//--- verif/bridge_ctl_monitor.sv
module bridge_ctl_monitor
  import bridge_ctl_pkg::*;
#(
  parameter int LONG_LIMIT  = TMO_LONG_CYCLES,
  parameter int SHORT_LIMIT = TMO_SHORT_CYCLES
) (
  input wire logic      clk,
  input wire logic      rst_b,
  input wire logic [31:0] cfg_rdata,
  input wire dly_evt_t  dly_evt [NUM_SIDES],
  input wire logic      dly_discard [NUM_SIDES],
  input wire logic      primary_system_error_out_n,
  input wire logic      wr_queue_full,
  input wire logic      wr_at_4k_boundary,
  input wire logic      wr_at_line_boundary,
  input wire logic      wr_disconnect,
  input wire read_cmd_t us_read_cmd,
  input wire logic      us_prefetch,
  input wire logic      us_forward_be,
  input wire logic      eff_io_en,
  input wire logic      eff_mem_en,
  input wire logic      accept_io_mem,
  input wire logic      fast_b2b_gen
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SD = SHORT_LIMIT + 1;
  localparam int LD = LONG_LIMIT + 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_fast_b2b_off: assert property (fast_b2b_gen == 1'b0) else $error("fast b2b generated");
  a_rsvd_reads_zero: assert property ((cfg_rdata & 32'hf08000cd) == 32'h0) else $error("reserved bit read 1");
  a_wr_disc_needed: assert property (wr_queue_full || wr_at_4k_boundary |-> wr_disconnect) else $error("no disc");
  a_wr_disc_none: assert property (!(wr_queue_full || wr_at_4k_boundary || wr_at_line_boundary) |->
    !wr_disconnect) else $error("stray disc");
  a_pf_be_excl: assert property (us_prefetch != us_forward_be) else $error("prefetch with be forward");
  a_line_mult_pf: assert property (us_read_cmd != RD_MEM |-> us_prefetch) else $error("line read no prefetch");
  a_accept_gated: assert property (accept_io_mem |-> eff_io_en || eff_mem_en) else $error("accept masked");
  a_serr_on_disc: assert property (!primary_system_error_out_n |->
    $past(dly_discard[0]) || $past(dly_discard[1])) else $error("serr without discard");
  a_pri_tmo_len: assert property (dly_discard[0] |->
    $past(dly_evt[0].cpl_at_head, SD) || $past(dly_evt[0].cpl_at_head, LD)) else $error("primary timeout length");
  a_sec_tmo_len: assert property (dly_discard[1] |->
    $past(dly_evt[1].cpl_at_head, SD) || $past(dly_evt[1].cpl_at_head, LD)) else $error("secondary timeout length");
  a_repeat_stops: assert property (dly_evt[0].repeat_seen || dly_evt[0].cpl_gone |=>
    !dly_discard[0] [*8]) else $error("discard after repeat");
  c_pri_discard: cover property (dly_discard[0]);
  c_sec_discard: cover property (dly_discard[1]);
  c_serr_pulse: cover property (!primary_system_error_out_n);
endmodule

//--- verif/dly_initiator.sv
module dly_initiator
  import bridge_ctl_pkg::*;
(
  input wire logic clk,
  output dly_evt_t dly_evt [NUM_SIDES]
);
  timeunit 1ns;
  timeprecision 1ps;
  initial dly_evt = '{default: '0};
  // k: 0 completion at head, 1 initiator repeat, 2 completion gone
  task automatic pulse(input int s, input int k);
    @(posedge clk);
    #1 dly_evt[s] = dly_evt_t'(3'b100 >> k);
    @(posedge clk);
    #1 dly_evt[s] = '0;
  endtask
endmodule

//--- verif/tb_bridge_timeout_and_chip_control.sv
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin err_count++; $display("unexpected %s exp=%h got=%h", nm, e, a); end end
module tb_bridge_timeout_and_chip_control import bridge_ctl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LONG_LIMIT  = 64;
  localparam int SHORT_LIMIT = 16;
  logic        clk, rst_b, cmd_io_en, cmd_mem_en, cmd_master_en, cmd_serr_en, hot_insert_pin, hot_pin_input_only;
  logic        wr_queue_full, wr_at_4k_boundary, wr_at_line_boundary, wr_disconnect, us_prefetch, us_forward_be;
  logic        us_single_dword, us_disconnect_first, eff_io_en, eff_mem_en, eff_master_en, accept_io_mem;
  logic        fast_b2b_gen, primary_system_error_out_n, pf, mk;
  logic [31:0] cfg_rdata, r;
  logic [7:0]  chip_m, bctl_m;
  cfg_req_t    cfg_req;
  read_cmd_t   us_read_cmd;
  dly_evt_t    dly_evt [NUM_SIDES];
  logic        dly_discard [NUM_SIDES];
  int          err_count, total_checks, seed, n;
  bridge_timeout_and_chip_control #(.LONG_LIMIT(LONG_LIMIT), .SHORT_LIMIT(SHORT_LIMIT)) i_bridge_timeout_and_chip_control (
    .clk(clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cmd_io_en(cmd_io_en),
    .cmd_mem_en(cmd_mem_en), .cmd_master_en(cmd_master_en), .cmd_serr_en(cmd_serr_en), .dly_evt(dly_evt),
    .dly_discard(dly_discard), .primary_system_error_out_n(primary_system_error_out_n),
    .wr_queue_full(wr_queue_full), .wr_at_4k_boundary(wr_at_4k_boundary), .wr_at_line_boundary(wr_at_line_boundary),
    .wr_disconnect(wr_disconnect), .us_read_cmd(us_read_cmd), .us_prefetch(us_prefetch), .us_forward_be(us_forward_be),
    .us_single_dword(us_single_dword), .us_disconnect_first(us_disconnect_first), .hot_insert_pin(hot_insert_pin),
    .hot_pin_input_only(hot_pin_input_only), .eff_io_en(eff_io_en), .eff_mem_en(eff_mem_en),
    .eff_master_en(eff_master_en), .accept_io_mem(accept_io_mem), .fast_b2b_gen(fast_b2b_gen));
  dly_initiator i_dly_initiator (.clk(clk), .dly_evt(dly_evt));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    cfg_req = '{1'b1, 1'b0, a, d, be};
    if (a == CHIP_CTL_ADDR && !be[CHIP_LANE]) chip_m = d[7:0] & CHIP_CTL_WMASK;
    if (a == BRIDGE_CTL_ADDR && !be[BRIDGE_LANE]) bctl_m = (d[31:24] & 8'h0b) | (bctl_m & ~d[31:24] & 8'h04);
    @(posedge clk);
    #1 cfg_req = '0;
    @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] exp_rdata(input logic [7:0] a);
    exp_rdata = (a == CHIP_CTL_ADDR) ? {24'h0, chip_m} : (a == BRIDGE_CTL_ADDR) ? {bctl_m, 24'h0} : 32'h0;
  endfunction
  task automatic cfg_chk(input logic [7:0] a);
    logic [31:0] e;
    e = exp_rdata(a);
    cfg_req = '{1'b0, 1'b1, a, 32'h0, 4'h0};
    @(posedge clk);
    #1 cfg_req = '0;
    @(posedge clk);
    #1 `CHK("cfg_rdata", e, cfg_rdata)
  endtask
  task automatic tmo(input int s, input logic sel, input logic en, input logic cmd);
    cfg_wr(BRIDGE_CTL_ADDR, {4'h0, en, 1'b0, sel, sel, 24'h0}, 4'h7);
    cmd_serr_en = cmd;
    i_dly_initiator.pulse(s, 0);
    n = 1;
    while (dly_discard[s] !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK("tmo_cycles", (sel ? SHORT_LIMIT : LONG_LIMIT) + 1, n)
    `CHK("serr_n_idle", 1'b1, primary_system_error_out_n)
    @(posedge clk);
    #1 `CHK("serr_n", !(en && cmd), primary_system_error_out_n)
    bctl_m[2] = 1'b1;
    // writing 0 must keep the status, writing 1 clears it
    cfg_wr(BRIDGE_CTL_ADDR, {4'h0, en, 1'b0, sel, sel, 24'h0}, 4'h7);
    cfg_chk(BRIDGE_CTL_ADDR);
    cfg_wr(BRIDGE_CTL_ADDR, {4'h0, en, 1'b1, sel, sel, 24'h0}, 4'h7);
    cfg_chk(BRIDGE_CTL_ADDR);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    err_count++;
    test_done();
  end
  initial begin
    seed = 32'he9d74a8c;
    {err_count, total_checks, chip_m, bctl_m} = '0;
    {cmd_io_en, cmd_mem_en, cmd_master_en, cmd_serr_en, hot_insert_pin, hot_pin_input_only} = '0;
    {wr_queue_full, wr_at_4k_boundary, wr_at_line_boundary, rst_b} = '0;
    cfg_req = '0;
    us_read_cmd = RD_MEM;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    cfg_chk(CHIP_CTL_ADDR);
    cfg_chk(BRIDGE_CTL_ADDR);
    cfg_chk(8'h44);
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      cfg_wr(BRIDGE_CTL_ADDR, r, {r[31] & r[30], 3'h7});
      cfg_wr(CHIP_CTL_ADDR, $random(seed), {3'h7, r[12] & r[13]});
      {cmd_io_en, cmd_mem_en, cmd_master_en, wr_queue_full, wr_at_4k_boundary} = r[4:0];
      {wr_at_line_boundary, hot_insert_pin, hot_pin_input_only} = r[7:5];
      us_read_cmd = read_cmd_t'(r[9:8] % 2'h3);
      repeat (2) @(posedge clk);
      #1 pf = chip_m[PF_DISABLE_BIT] && us_read_cmd == RD_MEM;
      mk = chip_m[LIVE_INS_BIT] & hot_pin_input_only & hot_insert_pin;
      `CHK("wr_disc", wr_queue_full | wr_at_4k_boundary | chip_m[WR_DISC_BIT] & wr_at_line_boundary, wr_disconnect)
      `CHK("prefetch", !pf, us_prefetch)
      `CHK("fwd_be", pf, us_forward_be)
      `CHK("single", pf, us_single_dword)
      `CHK("disc_first", pf, us_disconnect_first)
      `CHK("eff_en", {cmd_io_en, cmd_mem_en, cmd_master_en} & {3{!mk}}, {eff_io_en, eff_mem_en, eff_master_en})
      `CHK("accept", !mk & (cmd_io_en | cmd_mem_en), accept_io_mem)
      cfg_chk(BRIDGE_CTL_ADDR);
      cfg_chk(CHIP_CTL_ADDR);
    end
    tmo(0, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      tmo(i % 2, i / 2, r[0], r[1]);
    end
    for (int i = 0; i < 4; i++) begin
      cfg_wr(BRIDGE_CTL_ADDR, 32'h0300_0000, 4'h7);
      i_dly_initiator.pulse(i % 2, 0);
      repeat (5) @(posedge clk);
      i_dly_initiator.pulse(i % 2, 1 + i / 2);
      n = 0;
      repeat (SHORT_LIMIT + 8) begin
        @(posedge clk);
        #1 n += dly_discard[i % 2];
      end
      `CHK("late_discard", 0, n)
    end
    rst_b = 1'b0;
    @(posedge clk);
    #1 rst_b = 1'b1;
    {chip_m, bctl_m} = '0;
    cfg_chk(CHIP_CTL_ADDR);
    cfg_chk(BRIDGE_CTL_ADDR);
    test_done();
  end
endmodule
bind bridge_timeout_and_chip_control bridge_ctl_monitor #(.LONG_LIMIT(LONG_LIMIT), .SHORT_LIMIT(SHORT_LIMIT))
  i_bridge_ctl_monitor (.clk(clk), .rst_b(rst_b), .cfg_rdata(cfg_rdata), .dly_evt(dly_evt), .dly_discard(dly_discard),
  .primary_system_error_out_n(primary_system_error_out_n), .wr_queue_full(wr_queue_full),
  .wr_at_4k_boundary(wr_at_4k_boundary), .wr_at_line_boundary(wr_at_line_boundary), .wr_disconnect(wr_disconnect),
  .us_read_cmd(us_read_cmd), .us_prefetch(us_prefetch), .us_forward_be(us_forward_be), .eff_io_en(eff_io_en),
  .eff_mem_en(eff_mem_en), .accept_io_mem(accept_io_mem), .fast_b2b_gen(fast_b2b_gen));
